/* File: logic/cor_codec_one_regs.v */
// Purpose: control register bank of the first codec channel
// Assumes: register port driven by transport logic on i_clk_sys
// Notes: overflow input is asynchronous and is synchronised here
//
// Notes on behaviour
// RQ1 - registers 1-5 and 15 codec one, 6-10 and 16 codec two, rest global
// RQ2 - register 1 bits 7:4 hold D divisor minus one
// RQ3 - register 1 bits 3:0 hold N value as plain binary
// RQ4 - register 1 resets to 0101 0000, D six and N zero
// RQ5 - register 2 bits 7:4 hold I divisor minus one
// RQ6 - register 2 resets to 0101 0000, control bits all clear
// RQ7 - register 2 bit 3 set selects analog loopback
// RQ8 - register 2 bit 2 set selects digital loopback
// RQ9 - register 2 bit 1 set powers the channel down
// RQ10 - writing one to register 2 bit 0 restores codec one defaults
// RQ11 - register 3 bit 7 reports ADC overflow to readers
// RQ12 - register 3 bits 6:1 ADC gain, 110000 mute, 100001 12 dB, 1.5 dB steps
// RQ13 - ADC code 000001 gives -36 dB, code 000000 gives 0 dB
// RQ14 - register 3 bit 0 set routes the line output
// RQ15 - register 4 bits 7:6 unused, bits 5:0 DAC gain code
// RQ16 - DAC code 110000 mute, 100001..000001 12 to -36 dB, 000000 0 dB
// RQ17 - register 4 unused bits ignore writes and read zero
// RQ18 - overflow bit ignores writes and follows ADC overflow only
`timescale 1ns/100ps
`include "cor_map.vh"

module cor_codec_one_regs (
   input wire i_clk_sys,
   input wire i_arst_n,
   input wire [7:0] i_reg_addr,
   input wire i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_rd,
   input wire i_adc_overflow,
   output reg [7:0] o_rd_data,
   output reg o_rd_valid,
   output reg o_rd_hit,
   output reg o_soft_reset,
   output reg [4:0] o_rate_d,
   output reg [3:0] o_rate_n,
   output reg [4:0] o_rate_i,
   output reg o_analog_loopback,
   output reg o_digital_loopback,
   output reg o_power_down,
   output reg [5:0] o_adc_gain_code,
   output reg [7:0] o_adc_gain_half_db,
   output reg o_adc_mute,
   output reg o_line_output_route,
   output reg [5:0] o_dac_gain_code,
   output reg [7:0] o_dac_gain_half_db,
   output reg o_dac_mute
);

   ////////////////////////////////////////////////////////////////////////////
   // reset values at full 8-bit register width, divisor reset values at 5 bits

   localparam [7:0] RST_RATE_DN = `COR_RST_RATE_DN;
   localparam [7:0] RST_RATE_LBP = `COR_RST_RATE_LBP;
   localparam [7:0] RST_ADC_GAIN = `COR_RST_ADC_GAIN;
   localparam [7:0] RST_DAC_GAIN = `COR_RST_DAC_GAIN;
   localparam [4:0] RST_RATE_D = {1'b0, RST_RATE_DN[`COR_DIV_HI:`COR_DIV_LO]} + 5'h01;
   localparam [4:0] RST_RATE_I = {1'b0, RST_RATE_LBP[`COR_DIV_HI:`COR_DIV_LO]} + 5'h01;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // gain code to {mute, signed half-dB}
   function [8:0] gain_decode;
      input [5:0] code;
      reg [7:0] diff;
      begin
         diff = {2'b00, code} - `COR_GAIN_OFFSET;
         if (code == `COR_GAIN_ZERO) begin
            gain_decode = 9'h000; // RQ13
         end else if (code == `COR_GAIN_MUTE) begin
            gain_decode = 9'h100;
         end else if (code > `COR_GAIN_MAX) begin
            gain_decode = 9'h100;
         end else begin
            gain_decode = {1'b0, diff[7:0] * `COR_GAIN_STEP};
         end
      end
   endfunction

   // divisor field plus one
   function [4:0] div_value;
      input [3:0] field;
      begin
         div_value = {1'b0, field} + 5'h01;
      end
   endfunction

   // register address compare
   function addr_hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         addr_hit = (addr == target);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // overflow synchroniser

   reg ovf_meta;
   reg ovf_sync;

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ovf_meta <= 1'b0;
         ovf_sync <= 1'b0;
      end else begin
         ovf_meta <= i_adc_overflow;
         ovf_sync <= ovf_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decode

   wire sel_rate_dn;
   wire sel_rate_lbp;
   wire sel_adc_gain;
   wire sel_dac_gain;
   wire sel_any;

   assign sel_rate_dn = addr_hit(i_reg_addr, `COR_ADDR_RATE_DN); // RQ1
   assign sel_rate_lbp = addr_hit(i_reg_addr, `COR_ADDR_RATE_LBP); // RQ1
   assign sel_adc_gain = addr_hit(i_reg_addr, `COR_ADDR_ADC_GAIN); // RQ1
   assign sel_dac_gain = addr_hit(i_reg_addr, `COR_ADDR_DAC_GAIN); // RQ1
   assign sel_any = sel_rate_dn | sel_rate_lbp | sel_adc_gain | sel_dac_gain;

   ////////////////////////////////////////////////////////////////////////////
   // register storage

   reg [7:0] rate_dn;
   reg [7:0] rate_lbp;
   reg [6:0] adc_gain;
   reg [5:0] dac_gain;
   wire srst_hit;

   assign srst_hit = i_reg_wr & sel_rate_lbp & i_reg_wdata[`COR_BIT_SRST];

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rate_dn <= RST_RATE_DN; // RQ4
      end else if (srst_hit) begin
         rate_dn <= RST_RATE_DN; // RQ10
      end else if (i_reg_wr & sel_rate_dn) begin
         rate_dn <= i_reg_wdata; // RQ2 RQ3
      end
   end

   // soft reset bit is never stored
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rate_lbp <= RST_RATE_LBP; // RQ6
      end else if (srst_hit) begin
         rate_lbp <= RST_RATE_LBP; // RQ10
      end else if (i_reg_wr & sel_rate_lbp) begin
         rate_lbp <= {i_reg_wdata[7:1], 1'b0}; // RQ5
      end
   end

   // overflow bit is not stored
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         adc_gain <= RST_ADC_GAIN[6:0];
      end else if (srst_hit) begin
         adc_gain <= RST_ADC_GAIN[6:0]; // RQ10
      end else if (i_reg_wr & sel_adc_gain) begin
         adc_gain <= i_reg_wdata[6:0]; // RQ18
      end
   end

   // unused top bits are not stored
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dac_gain <= RST_DAC_GAIN[5:0];
      end else if (srst_hit) begin
         dac_gain <= RST_DAC_GAIN[5:0]; // RQ10
      end else if (i_reg_wr & sel_dac_gain) begin
         dac_gain <= i_reg_wdata[5:0]; // RQ17
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // soft reset pulse for registers held elsewhere

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_soft_reset <= 1'b0;
      end else begin
         o_soft_reset <= srst_hit; // RQ10
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   reg [7:0] next_rd_data;

   always @* begin
      next_rd_data = 8'h00;
      case (i_reg_addr)
         `COR_ADDR_RATE_DN: begin
            next_rd_data = rate_dn;
         end
         `COR_ADDR_RATE_LBP: begin
            next_rd_data = rate_lbp;
         end
         `COR_ADDR_ADC_GAIN: begin
            next_rd_data = {ovf_sync, adc_gain}; // RQ11 RQ18
         end
         `COR_ADDR_DAC_GAIN: begin
            next_rd_data = {2'b00, dac_gain}; // RQ15 RQ17
         end
         default: begin
            next_rd_data = 8'h00;
         end
      endcase
   end

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rd_data <= 8'h00;
         o_rd_valid <= 1'b0;
         o_rd_hit <= 1'b0;
      end else begin
         o_rd_valid <= i_reg_rd;
         if (i_reg_rd) begin
            o_rd_data <= next_rd_data;
            o_rd_hit <= sel_any;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decoded controls

   wire [5:0] adc_code;
   wire [5:0] dac_code;
   reg [8:0] next_adc_dec;
   reg [8:0] next_dac_dec;

   assign adc_code = adc_gain[`COR_ADC_GAIN_HI:`COR_ADC_GAIN_LO]; // RQ12
   assign dac_code = dac_gain[`COR_DAC_GAIN_HI:`COR_DAC_GAIN_LO]; // RQ15

   always @* begin
      next_adc_dec = gain_decode(adc_code); // RQ12 RQ13
      next_dac_dec = gain_decode(dac_code); // RQ16
   end

   ////////////////////////////////////////////////////////////////////////////
   // rate and mode controls

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rate_d <= RST_RATE_D;
         o_rate_n <= RST_RATE_DN[`COR_NVAL_HI:`COR_NVAL_LO];
         o_rate_i <= RST_RATE_I;
         o_analog_loopback <= RST_RATE_LBP[`COR_BIT_ALOOP];
         o_digital_loopback <= RST_RATE_LBP[`COR_BIT_DLOOP];
         o_power_down <= RST_RATE_LBP[`COR_BIT_PDOWN];
      end else begin
         o_rate_d <= div_value(rate_dn[`COR_DIV_HI:`COR_DIV_LO]); // RQ2
         o_rate_n <= rate_dn[`COR_NVAL_HI:`COR_NVAL_LO]; // RQ3
         o_rate_i <= div_value(rate_lbp[`COR_DIV_HI:`COR_DIV_LO]); // RQ5
         o_analog_loopback <= rate_lbp[`COR_BIT_ALOOP]; // RQ7
         o_digital_loopback <= rate_lbp[`COR_BIT_DLOOP]; // RQ8
         o_power_down <= rate_lbp[`COR_BIT_PDOWN]; // RQ9
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // adc gain and line output controls

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_adc_gain_code <= RST_ADC_GAIN[`COR_ADC_GAIN_HI:`COR_ADC_GAIN_LO];
         o_adc_gain_half_db <= 8'h00;
         o_adc_mute <= 1'b0;
         o_line_output_route <= RST_ADC_GAIN[`COR_BIT_LINE];
      end else begin
         o_adc_gain_code <= adc_code; // RQ12
         o_adc_gain_half_db <= next_adc_dec[7:0]; // RQ12
         o_adc_mute <= next_adc_dec[8]; // RQ12
         o_line_output_route <= adc_gain[`COR_BIT_LINE]; // RQ14
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dac gain controls

   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_dac_gain_code <= RST_DAC_GAIN[`COR_DAC_GAIN_HI:`COR_DAC_GAIN_LO];
         o_dac_gain_half_db <= 8'h00;
         o_dac_mute <= 1'b0;
      end else begin
         o_dac_gain_code <= dac_code; // RQ15
         o_dac_gain_half_db <= next_dac_dec[7:0]; // RQ16
         o_dac_mute <= next_dac_dec[8]; // RQ16
      end
   end

endmodule

/* File: shared/cor_map.vh */
// Purpose: constants for the first codec channel control registers
// Assumes: 8-bit register addresses and data
// Notes: offsets, field positions, reset values and gain codes
`ifndef COR_MAP_VH
`define COR_MAP_VH

// register addresses
`define COR_ADDR_RATE_DN 8'h01
`define COR_ADDR_RATE_LBP 8'h02
`define COR_ADDR_ADC_GAIN 8'h03
`define COR_ADDR_DAC_GAIN 8'h04

// reset values
`define COR_RST_RATE_DN 8'h50
`define COR_RST_RATE_LBP 8'h50
`define COR_RST_ADC_GAIN 8'h00
`define COR_RST_DAC_GAIN 8'h00

// field positions
`define COR_DIV_HI 7
`define COR_DIV_LO 4
`define COR_NVAL_HI 3
`define COR_NVAL_LO 0
`define COR_BIT_ALOOP 3
`define COR_BIT_DLOOP 2
`define COR_BIT_PDOWN 1
`define COR_BIT_SRST 0
`define COR_BIT_OVF 7
`define COR_ADC_GAIN_HI 6
`define COR_ADC_GAIN_LO 1
`define COR_BIT_LINE 0
`define COR_DAC_GAIN_HI 5
`define COR_DAC_GAIN_LO 0

// gain codes, half-dB units
`define COR_GAIN_MUTE 6'h30
`define COR_GAIN_MAX 6'h21
`define COR_GAIN_ZERO 6'h00
`define COR_GAIN_OFFSET 8'h19
`define COR_GAIN_STEP 8'h03

`endif

/* File: dv/cor_codec_one_regs_props.sv */
// Purpose: port assertions for the codec one register bank
// Assumes: one clock, async active-low reset
// Notes: write checks need an idle cycle after the write
`timescale 1ns/100ps
module cor_codec_one_regs_props (
   input wire i_clk_sys,
   input wire i_arst_n,
   input wire [7:0] i_reg_addr,
   input wire i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_rd,
   input wire [7:0] o_rd_data,
   input wire o_rd_valid,
   input wire o_rd_hit,
   input wire o_soft_reset,
   input wire [4:0] o_rate_d,
   input wire [3:0] o_rate_n,
   input wire [4:0] o_rate_i,
   input wire o_analog_loopback,
   input wire o_digital_loopback,
   input wire o_power_down,
   input wire [5:0] o_adc_gain_code,
   input wire [7:0] o_adc_gain_half_db,
   input wire o_line_output_route,
   input wire [5:0] o_dac_gain_code,
   input wire o_dac_mute
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_arst_n);
   wire [7:0] d = i_reg_wdata;
   wire [7:0] a = i_reg_addr;
   AST_UNMAPPED: assert property (i_reg_rd && (a == 8'h00 || a > 8'h04) |=> o_rd_valid && !o_rd_hit &&
      o_rd_data == 8'h00) else $error("unmapped read answered wrongly");
   AST_RATE_DN: assert property (i_reg_wr && a == 8'h01 ##1 !i_reg_wr |=>
      o_rate_d == {1'b0, $past(d[7:4], 2)} + 5'h01 && o_rate_n == $past(d[3:0], 2)) else $error("rate d or n wrong");
   AST_RATE_I: assert property (i_reg_wr && a == 8'h02 && !d[0] ##1 !i_reg_wr |=>
      o_rate_i == {1'b0, $past(d[7:4], 2)} + 5'h01 &&
      {o_analog_loopback, o_digital_loopback, o_power_down} == $past(d[3:1], 2)) else $error("reg2 decode wrong");
   AST_SOFT: assert property (i_reg_wr && a == 8'h02 && d[0] ##1 !i_reg_wr |-> o_soft_reset ##1
      (o_rate_d == 5'h06 && o_rate_i == 5'h06 && o_dac_gain_code == 6'h00)) else $error("soft reset wrong");
   AST_ADC: assert property (i_reg_wr && a == 8'h03 ##1 !i_reg_wr |=>
      o_adc_gain_code == $past(d[6:1], 2) && o_line_output_route == $past(d[0], 2)) else $error("adc field wrong");
   AST_ADC_MIN: assert property (i_reg_wr && a == 8'h03 && d[6:1] == 6'h01 ##1 !i_reg_wr |=>
      o_adc_gain_half_db == 8'hb8) else $error("adc minimum gain wrong");
   AST_DAC: assert property (i_reg_wr && a == 8'h04 ##1 !i_reg_wr |=>
      o_dac_gain_code == $past(d[5:0], 2) && o_dac_mute == ($past(d[5:0], 2) >= 6'h22)) else $error("dac field wrong");
   AST_UNUSED: assert property (i_reg_rd && a == 8'h04 |=> o_rd_hit && o_rd_data[7:6] == 2'b00)
      else $error("reg4 unused bits not zero");
   cover property (i_reg_wr && a == 8'h02 && d[0]);
   cover property (i_reg_rd && a == 8'h03 ##1 o_rd_data[7]);
   cover property (i_reg_wr && a == 8'h04 && d[5:0] == 6'h30);
endmodule
bind cor_codec_one_regs cor_codec_one_regs_props u_props (.i_clk_sys, .i_arst_n, .i_reg_addr, .i_reg_wr,
   .i_reg_wdata, .i_reg_rd, .o_rd_data, .o_rd_valid, .o_rd_hit, .o_soft_reset, .o_rate_d, .o_rate_n, .o_rate_i,
   .o_analog_loopback, .o_digital_loopback, .o_power_down, .o_adc_gain_code, .o_adc_gain_half_db,
   .o_line_output_route, .o_dac_gain_code, .o_dac_mute);

/* File: dv/cor_host_model.sv */
// Purpose: host model driving the register port
// Assumes: one-cycle strobes on i_clk_sys
// Notes: released lines show inverted values
`timescale 1ns/100ps
module cor_host_model (
   input wire i_clk_sys,
   input wire [7:0] i_rd_data,
   input wire i_rd_valid,
   output reg [7:0] o_reg_addr = 8'h00,
   output reg o_reg_wr = 1'b0,
   output reg [7:0] o_reg_wdata = 8'h00,
   output reg o_reg_rd = 1'b0
);
   task automatic wr_reg(input [7:0] addr, input [7:0] data);
      @(posedge i_clk_sys);
      o_reg_addr <= addr;
      o_reg_wdata <= data;
      o_reg_wr <= 1'b1;
      @(posedge i_clk_sys);
      o_reg_wr <= 1'b0;
      o_reg_wdata <= ~data;
   endtask
   task automatic rd_reg(input [7:0] addr, output [7:0] data, output valid);
      @(posedge i_clk_sys);
      o_reg_addr <= addr;
      o_reg_rd <= 1'b1;
      @(posedge i_clk_sys);
      o_reg_rd <= 1'b0;
      o_reg_addr <= ~addr;
      @(negedge i_clk_sys);
      data = i_rd_data;
      valid = i_rd_valid;
   endtask
endmodule

/* File: dv/codec_one_control_regs_tb_top.sv */
// Purpose: self-checking bench for the codec one register bank
// Assumes: host model drives the register port
// Notes: decoded outputs sampled two cycles after a write
`timescale 1ns/100ps
`include "cor_map.vh"
module codec_one_control_regs_tb_top;
   logic i_clk_sys, i_arst_n, i_adc_overflow;
   wire [7:0] i_reg_addr, i_reg_wdata, o_rd_data, o_adc_gain_half_db, o_dac_gain_half_db;
   wire [4:0] o_rate_d, o_rate_i;
   wire [3:0] o_rate_n;
   wire [5:0] o_adc_gain_code, o_dac_gain_code;
   wire i_reg_wr, i_reg_rd, o_rd_valid, o_rd_hit, o_soft_reset, o_analog_loopback, o_digital_loopback;
   wire o_power_down, o_adc_mute, o_line_output_route, o_dac_mute;
   int err_count = 0, cmp_count = 0;
   cor_codec_one_regs u_dut (.i_clk_sys, .i_arst_n, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
      .i_adc_overflow, .o_rd_data, .o_rd_valid, .o_rd_hit, .o_soft_reset, .o_rate_d, .o_rate_n, .o_rate_i,
      .o_analog_loopback, .o_digital_loopback, .o_power_down, .o_adc_gain_code, .o_adc_gain_half_db, .o_adc_mute,
      .o_line_output_route, .o_dac_gain_code, .o_dac_gain_half_db, .o_dac_mute);
   cor_host_model u_host (.i_clk_sys, .i_rd_data(o_rd_data), .i_rd_valid(o_rd_valid), .o_reg_addr(i_reg_addr),
      .o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd));
   task automatic chk(input string name, input [7:0] exp, input [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rd_chk(input [7:0] addr, input [7:0] exp);
      logic [7:0] d;
      logic v;
      u_host.rd_reg(addr, d, v);
      chk("rd_valid", 8'h01, {7'h00, v});
      chk("rd_data", exp, d);
   endtask
   task automatic t_defaults(input [7:0] a0);
      for (int a = 1; a <= 4; a++) rd_chk(a0 + a[7:0], (a < 3) ? 8'h50 : 8'h00);
      chk("rate_d", 8'h06, {3'h0, o_rate_d});
      chk("rate_i", 8'h06, {3'h0, o_rate_i});
   endtask
   task automatic t_rates;
      u_host.wr_reg(`COR_ADDR_RATE_DN, 8'hf3);
      u_host.wr_reg(`COR_ADDR_RATE_LBP, 8'h3a);
      repeat (2) @(negedge i_clk_sys);
      chk("rate_d", 8'h10, {3'h0, o_rate_d});
      chk("rate_n", 8'h03, {4'h0, o_rate_n});
      chk("rate_i", 8'h04, {3'h0, o_rate_i});
      chk("loop_pd", 8'h05, {5'h00, o_analog_loopback, o_digital_loopback, o_power_down});
      rd_chk(`COR_ADDR_RATE_DN, 8'hf3);
      rd_chk(`COR_ADDR_RATE_LBP, 8'h3a);
   endtask
   task automatic t_gains;
      logic [5:0] codes [5] = '{6'h30, 6'h21, 6'h01, 6'h00, 6'h19};
      logic [7:0] half;
      foreach (codes[i]) begin
         u_host.wr_reg(`COR_ADDR_ADC_GAIN, {1'b1, codes[i], 1'b1});
         u_host.wr_reg(`COR_ADDR_DAC_GAIN, {2'b11, codes[i]});
         repeat (2) @(negedge i_clk_sys);
         half = (codes[i] == 6'h00) ? 8'h00 : ({2'b00, codes[i]} - 8'h19) * 8'h03;
         chk("mutes", {6'h00, {2{codes[i] == 6'h30}}}, {6'h00, o_adc_mute, o_dac_mute});
         if (codes[i] != 6'h30) chk("adc_half_db", half, o_adc_gain_half_db);
         if (codes[i] != 6'h30) chk("dac_half_db", half, o_dac_gain_half_db);
         chk("line_route", 8'h01, {7'h00, o_line_output_route});
         rd_chk(`COR_ADDR_ADC_GAIN, {1'b0, codes[i], 1'b1});
         rd_chk(`COR_ADDR_DAC_GAIN, {2'b00, codes[i]});
      end
      @(posedge i_clk_sys) i_adc_overflow <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      rd_chk(`COR_ADDR_ADC_GAIN, 8'hb3);
      @(posedge i_clk_sys) i_adc_overflow <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
   endtask
   task automatic t_soft_unmapped;
      u_host.wr_reg(`COR_ADDR_RATE_LBP, 8'hff);
      repeat (2) @(negedge i_clk_sys);
      t_defaults(8'h00);
      u_host.wr_reg(8'h05, 8'haa);
      rd_chk(8'h05, 8'h00);
      chk("rd_hit", 8'h00, {7'h00, o_rd_hit});
      rd_chk(8'hff, 8'h00);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #200000 err_count++;
      summarize();
   end
   initial begin
      i_arst_n = 1'b0;
      i_adc_overflow = 1'b0;
      repeat (3) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      t_defaults(8'h00);
      t_rates();
      t_gains();
      t_soft_unmapped();
      summarize();
   end
endmodule
